// ===== gyro_fmt_defines.svh
// Purpose: Named constants for the gyro output word formatter
// Assumes: APB byte addresses, 32-bit data, 10 MHz pclk
// Notes: Definitions only
`ifndef GYRO_FMT_DEFINES_SVH
`define GYRO_FMT_DEFINES_SVH
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_TRIM0 12'h008
`define OFS_TRIM1 12'h00C
`define OFS_TRIM2 12'h010
`define OFS_SAMPLE 12'h014
`define OFS_TEMP 12'h018
`define OFS_LAT 12'h01C
`define OFS_RATE0 12'h020
`define OFS_RATE1 12'h024
`define OFS_RATE2 12'h028
`define OFS_CMD 12'h02C
`define OFS_INFO 12'h030
`define CTRL_UNIT_LSB 0
`define CTRL_RATIO_LSB 2
`define CTRL_FILT_LSB 6
`define CMD_SERVICE 0
`define CMD_EXIT 1
`define CMD_EXIT_NORMAL 2
`define CMD_SHOT 3
`define CTRL_RESET 32'h0000_0020
`define SAMPLE_PERIOD_US 500
`define CLK_PERIOD_NS 100
`define SAMPLE_CYCLES ((`SAMPLE_PERIOD_US * 1000) / `CLK_PERIOD_NS)
`define US_CYCLES (1000 / `CLK_PERIOD_NS)
`define INFO_WORD 32'h0000_5A5A
`endif

// ===== gyro_fmt_pkg.sv
// Purpose: Types for the gyro output word formatter
// Assumes: Included defines are shared with the modules
// Notes: Unit and mode enumerations
package gyro_fmt_pkg;
  typedef enum logic [1:0] {
    UNIT_RATE = 2'b00,
    UNIT_AVERAGE = 2'b01,
    UNIT_INCREMENT = 2'b10,
    UNIT_INTEGRATED = 2'b11
  } out_unit_t;
  typedef enum logic [1:0] {
    MODE_INIT = 2'b00,
    MODE_NORMAL = 2'b01,
    MODE_SERVICE = 2'b10
  } dev_mode_t;
endpackage : gyro_fmt_pkg

// ===== axis_path.sv
// Purpose: One axis: filter, trim, averaging and integration
// Assumes: smp_tick once per internal sample, tx_tick at each output slot
// Notes: Values in 2^-14 deg/s units, angle in 2^-21 deg units
`timescale 1ns/10ps
`include "gyro_fmt_defines.svh"
module axis_path
  import gyro_fmt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic smp_tick,
  input wire logic tx_tick,
  input wire logic [23:0] comp_rate,
  input wire logic [23:0] trim,
  input wire logic [2:0] filt_shift,
  input wire logic [1:0] unit,
  output logic [23:0] rate_word_bytes,
  output logic [23:0] angle_word_bytes
);
  logic signed [31:0] filt_reg;
  logic signed [31:0] sum_reg;
  logic signed [31:0] incr_reg;
  logic [3:0] cnt_reg;
  logic signed [23:0] adj;
  logic signed [31:0] adj_ext;
  logic signed [31:0] sum_next;
  logic signed [31:0] incr_next;
  logic [23:0] angle_reg;
  logic [23:0] last_reg;
  logic signed [31:0] filt_next;
  logic [3:0] cnt_next;
  logic [23:0] angle_next;

  // Trim is added after compensation, in rate units always
  assign adj = $signed(comp_rate) + $signed(trim);
  assign adj_ext = {{8{adj[23]}}, adj};
  // The slot sample itself belongs to the slot, so outputs use the new filter value
  assign filt_next = filt_reg + ((adj_ext - filt_reg) >>> filt_shift);
  assign cnt_next = cnt_reg + 4'h1;
  assign sum_next = sum_reg + filt_next;
  // Rate * 1/2000 s in 2^-21 deg units is rate * 128 / 2000 = rate * 8 / 125
  assign incr_next = incr_reg + ((filt_next <<< 3) / 32'sd125);
  assign angle_next = angle_reg + 24'((filt_next <<< 3) / 32'sd125);

  // Single-pole low-pass; it keeps running whatever the mode is
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_reg <= 32'sh0;
    end else if (smp_tick) begin
      filt_reg <= filt_next;
    end
  end

  // Integrated angle never clears between slots; the 24-bit field wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      angle_reg <= 24'h0;
    end else if (smp_tick) begin
      angle_reg <= angle_next;
    end
  end

  // Mean of samples since last slot; output slot captures then restarts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum_reg <= 32'sh0;
      incr_reg <= 32'sh0;
      cnt_reg <= 4'h0;
      last_reg <= 24'h0;
      rate_word_bytes <= 24'h0;
      angle_word_bytes <= 24'h0;
    end else if (tx_tick) begin
      last_reg <= filt_next[23:0];
      unique case (out_unit_t'(unit))
        UNIT_RATE: rate_word_bytes <= filt_next[23:0];
        UNIT_AVERAGE: rate_word_bytes <= 24'(sum_next / $signed({28'h0, cnt_next}));
        UNIT_INCREMENT: angle_word_bytes <= incr_next[23:0];
        UNIT_INTEGRATED: angle_word_bytes <= angle_next;
      endcase
      sum_reg <= 32'sh0;
      incr_reg <= 32'sh0;
      cnt_reg <= 4'h0;
    end else if (smp_tick) begin
      sum_reg <= sum_next;
      incr_reg <= incr_next;
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  // A slot after exactly eight samples reports their mean
  avg_eight_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_tick && unit == UNIT_AVERAGE && cnt_reg == 4'h7)
      |=> rate_word_bytes == 24'($past(sum_next) / 32'sd8))
    else $error("average word wrong");
  integ_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_tick |=> angle_reg == $past(angle_next))
    else $error("integrated angle cleared");
endmodule : axis_path

// ===== gyro_output_unit_formatter.sv
// Purpose: Per-axis output words, counter, temperature, latency, mode control
// Assumes: APB slave at 10 MHz; compensated rate and temperature arrive synchronous
// Notes: Notes on behaviour below
`timescale 1ns/10ps
`include "gyro_fmt_defines.svh"
module gyro_output_unit_formatter
  import gyro_fmt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [71:0] comp_rate,
  input wire logic [47:0] comp_temp,
  input wire logic ext_trigger,
  input wire logic utility_mode,
  input wire logic flash_done,
  output logic flash_reload,
  output logic info_valid,
  output logic [31:0] info_data,
  output logic dgram_valid,
  output logic [71:0] rate_word_bytes,
  output logic [71:0] angle_word_bytes,
  output logic [47:0] temp_bytes,
  output logic [7:0] sample_count,
  output logic [15:0] latency_bytes
);
  logic [31:0] ctrl_reg;
  logic [31:0] shadow_reg;
  logic [23:0] trim_reg [3];
  logic [23:0] trim_next;
  dev_mode_t mode_reg;
  logic [15:0] smp_cnt_reg;
  logic smp_tick;
  logic [3:0] slot_cnt_reg;
  logic tx_tick;
  logic shot_reg;
  logic [7:0] count_reg;
  logic [3:0] us_div_reg;
  logic [15:0] lat_reg;
  logic trig_s1_reg;
  logic trig_s2_reg;
  logic trig_d_reg;
  logic trig_rise;
  logic lat_run_reg;
  logic [71:0] rate_w;
  logic [71:0] angle_w;
  logic wr;
  logic rd;
  logic trim_ok;

  // Register offset check used only for the pslverr error response
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a <= `OFS_INFO) && (a[1:0] == 2'b00);
  endfunction : mapped

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1; // Zero wait states
  assign pslverr = psel && penable && !mapped(paddr);
  assign trim_ok = (mode_reg == MODE_SERVICE) || utility_mode;

  // Internal sample clock: 2000 samples per second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_cnt_reg <= 16'h0;
    end else begin
      smp_cnt_reg <= (smp_cnt_reg == 16'(`SAMPLE_CYCLES - 1)) ? 16'h0 : smp_cnt_reg + 16'h1;
    end
  end
  assign smp_tick = (smp_cnt_reg == 16'(`SAMPLE_CYCLES - 1));

  // Output slot every n samples; ratio field holds n (8 gives 250/s)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_cnt_reg <= 4'h0;
    end else if (smp_tick) begin
      slot_cnt_reg <= (slot_cnt_reg + 4'h1 >= ctrl_reg[`CTRL_RATIO_LSB +: 4]) ? 4'h0 :
        slot_cnt_reg + 4'h1;
    end
  end
  assign tx_tick = smp_tick && (slot_cnt_reg + 4'h1 >= ctrl_reg[`CTRL_RATIO_LSB +: 4]);

  // Eight-bit counter wraps freely with no error flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 8'h0;
    end else if (smp_tick) begin
      count_reg <= count_reg + 8'h1;
    end
  end

  // Trigger pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_s1_reg <= 1'b0;
      trig_s2_reg <= 1'b0;
      trig_d_reg <= 1'b0;
    end else begin
      trig_s1_reg <= ext_trigger;
      trig_s2_reg <= trig_s1_reg;
      trig_d_reg <= trig_s2_reg;
    end
  end
  assign trig_rise = trig_s2_reg && !trig_d_reg;

  // Latency from trigger to next slot in microseconds, held at 65535
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_reg <= 16'h0;
      us_div_reg <= 4'h0;
      lat_run_reg <= 1'b0;
    end else if (trig_rise) begin
      lat_reg <= 16'h0;
      us_div_reg <= 4'h0;
      lat_run_reg <= 1'b1;
    end else if (tx_tick) begin
      lat_run_reg <= 1'b0;
    end else if (lat_run_reg) begin
      us_div_reg <= (us_div_reg == 4'(`US_CYCLES - 1)) ? 4'h0 : us_div_reg + 4'h1;
      if (us_div_reg == 4'(`US_CYCLES - 1) && lat_reg != 16'hFFFF) begin
        lat_reg <= lat_reg + 16'h1;
      end
    end
  end

  // Mode control; a reset from presetn always lands in init
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= MODE_INIT;
    end else begin
      unique case (mode_reg)
        MODE_INIT: if (flash_done) mode_reg <= MODE_NORMAL;
        MODE_NORMAL: if (wr && paddr == `OFS_CMD && pwdata[`CMD_SERVICE]) begin
          mode_reg <= MODE_SERVICE;
        end
        MODE_SERVICE: if (wr && paddr == `OFS_CMD && pwdata[`CMD_EXIT]) begin
          mode_reg <= pwdata[`CMD_EXIT_NORMAL] ? MODE_NORMAL : MODE_INIT;
        end
        default: mode_reg <= MODE_INIT;
      endcase
    end
  end
  assign flash_reload = (mode_reg == MODE_INIT);

  // Saved configuration copy; init restores it over unsaved edits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CTRL_RESET;
      shadow_reg <= `CTRL_RESET;
    end else if (mode_reg == MODE_INIT) begin
      ctrl_reg <= shadow_reg;
    end else if (wr && paddr == `OFS_CTRL) begin
      ctrl_reg <= pwdata;
    end
  end

  // Trim writes accepted only in utility or service mode
  assign trim_next = pwdata[23:0];
  generate
    for (genvar g = 0; g < 3; g++) begin : g_trim
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          trim_reg[g] <= 24'h0;
        end else if (wr && trim_ok && paddr == 12'(`OFS_TRIM0 + 4 * g)) begin
          trim_reg[g] <= trim_next;
        end
      end
      axis_path u_axis (
        .pclk(pclk),
        .presetn(presetn),
        .smp_tick(smp_tick),
        .tx_tick(tx_tick),
        .comp_rate(comp_rate[24 * g +: 24]),
        .trim(trim_reg[g]),
        .filt_shift(ctrl_reg[`CTRL_FILT_LSB +: 3]),
        .unit(ctrl_reg[`CTRL_UNIT_LSB +: 2]),
        .rate_word_bytes(rate_w[24 * g +: 24]),
        .angle_word_bytes(angle_w[24 * g +: 24])
      );
    end
  endgenerate

  // Info on service entry; single shot pending until next slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      info_valid <= 1'b0;
      info_data <= 32'h0;
      shot_reg <= 1'b0;
    end else begin
      info_valid <= (mode_reg == MODE_NORMAL) && wr && paddr == `OFS_CMD &&
        pwdata[`CMD_SERVICE];
      info_data <= `INFO_WORD;
      if (tx_tick) begin
        shot_reg <= 1'b0;
      end else if (mode_reg == MODE_SERVICE && wr && paddr == `OFS_CMD && pwdata[`CMD_SHOT]) begin
        shot_reg <= 1'b1;
      end
    end
  end

  // Datagram strobe: normal mode, or one single shot in service mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dgram_valid <= 1'b0;
      temp_bytes <= 48'h0;
      sample_count <= 8'h0;
      latency_bytes <= 16'h0;
    end else begin
      dgram_valid <= tx_tick && (mode_reg == MODE_NORMAL || (mode_reg == MODE_SERVICE && shot_reg));
      if (tx_tick) begin
        temp_bytes <= comp_temp;
        sample_count <= count_reg;
        latency_bytes <= lat_reg;
      end
    end
  end
  assign rate_word_bytes = rate_w;
  assign angle_word_bytes = angle_w;

  // Register readback
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `OFS_CTRL: prdata <= ctrl_reg;
        `OFS_STATUS: prdata <= {29'h0, shot_reg, mode_reg};
        `OFS_TRIM0: prdata <= {8'h0, trim_reg[0]};
        `OFS_TRIM1: prdata <= {8'h0, trim_reg[1]};
        `OFS_TRIM2: prdata <= {8'h0, trim_reg[2]};
        `OFS_SAMPLE: prdata <= {24'h0, count_reg};
        `OFS_TEMP: prdata <= {16'h0, comp_temp[15:0]};
        `OFS_LAT: prdata <= {16'h0, lat_reg};
        `OFS_RATE0: prdata <= {8'h0, rate_w[23:0]};
        `OFS_RATE1: prdata <= {8'h0, rate_w[47:24]};
        `OFS_RATE2: prdata <= {8'h0, rate_w[71:48]};
        `OFS_INFO: prdata <= `INFO_WORD;
        default: prdata <= 32'h0;
      endcase
    end
  end

  sequence svc_entry_s;
    mode_reg == MODE_NORMAL && wr && paddr == `OFS_CMD && pwdata[`CMD_SERVICE];
  endsequence
  svc_info_a: assert property (@(posedge pclk) disable iff (!presetn)
    svc_entry_s |=> info_valid && mode_reg == MODE_SERVICE)
    else $error("no info on service entry");
  svc_silent_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg == MODE_SERVICE && !shot_reg) |=> !dgram_valid)
    else $error("datagram in service mode");
  trim_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg != MODE_SERVICE && !utility_mode) |=> $stable(trim_reg[0]))
    else $error("trim changed while locked");
  count_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (smp_tick && count_reg == 8'hFF) |=> count_reg == 8'h00)
    else $error("counter wrap wrong");
  exit_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg == MODE_SERVICE && wr && paddr == `OFS_CMD && pwdata[`CMD_EXIT])
      |=> mode_reg == ($past(pwdata[`CMD_EXIT_NORMAL]) ? MODE_NORMAL : MODE_INIT))
    else $error("exit target wrong");
  normal_tx_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_tick && mode_reg == MODE_NORMAL) |=> dgram_valid && sample_count == $past(count_reg))
    else $error("normal datagram missing");
  lat_sat_a: assert property (@(posedge pclk) disable iff (!presetn)
    (lat_reg == 16'hFFFF && !trig_rise) |=> lat_reg == 16'hFFFF)
    else $error("latency wrapped");
  init_restore_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode_reg == MODE_INIT |=> ctrl_reg == $past(shadow_reg))
    else $error("config not reloaded");
endmodule : gyro_output_unit_formatter

// ===== host_link_model.sv
// Purpose: Host-side stand-in that logs datagrams and answers a config reload
// Assumes: dgram_valid is a one-cycle pulse per transmitted datagram
// Notes: flash_done follows flash_reload after a fixed short delay
`timescale 1ns/10ps
module host_link_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic dgram_valid,
  input wire logic flash_reload,
  output logic flash_done,
  output logic [15:0] dgram_cnt
);
  logic [3:0] wait_reg;

  // Count every datagram the host receives, so silence can be proven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dgram_cnt <= 16'h0000;
    end else if (dgram_valid) begin
      dgram_cnt <= dgram_cnt + 16'h0001;
    end
  end

  // Storage answers slowly; a done that came at once would hide ordering bugs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg <= 4'h0;
      flash_done <= 1'b0;
    end else if (!flash_reload) begin
      wait_reg <= 4'h0;
      flash_done <= 1'b0;
    end else if (wait_reg != 4'hF) begin
      wait_reg <= wait_reg + 4'h1;
    end else begin
      flash_done <= 1'b1;
    end
  end
endmodule : host_link_model

// ===== gyro_output_unit_formatter_test.sv
// Purpose: Self-checking bench for the gyro output word formatter
// Assumes: Zero-wait APB slave, one internal sample every 5000 pclk
// Notes: Ratio 1 or 2 keeps slots short; filter stays at pass-through
`timescale 1ns/10ps
`include "gyro_fmt_defines.svh"
module gyro_output_unit_formatter_test;
  import gyro_fmt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic ext_trigger, utility_mode, flash_done, flash_reload, info_valid, dgram_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, info_data, rd;
  logic [71:0] comp_rate, rate_word_bytes, angle_word_bytes, a0;
  logic [47:0] comp_temp, temp_bytes;
  logic [7:0] sample_count, sc0;
  logic [15:0] latency_bytes, dgram_cnt, c0;
  int err_total = 0;
  int n_checks = 0;

  // 10 MHz clock
  always #50 pclk = ~pclk;

  gyro_output_unit_formatter dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comp_rate(comp_rate), .comp_temp(comp_temp),
    .ext_trigger(ext_trigger), .utility_mode(utility_mode), .flash_done(flash_done),
    .flash_reload(flash_reload), .info_valid(info_valid), .info_data(info_data),
    .dgram_valid(dgram_valid), .rate_word_bytes(rate_word_bytes),
    .angle_word_bytes(angle_word_bytes), .temp_bytes(temp_bytes),
    .sample_count(sample_count), .latency_bytes(latency_bytes));

  host_link_model host (.pclk(pclk), .presetn(presetn), .dgram_valid(dgram_valid),
    .flash_reload(flash_reload), .flash_done(flash_done), .dgram_cnt(dgram_cnt));

  // Verdict and end of run, also reached by any wait that runs out
  task automatic report_and_stop;
    if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // Exact four-state compare
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_up;
    err_total++;
    report_and_stop();
  endtask : give_up

  // One APB transfer; entered just after a rising edge, request held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) give_up();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so a following call never drives psel twice in a time step
    @(posedge pclk);
  endtask : apb

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(72'(rd), 72'(e));
  endtask : rchk

  // Returns at the edge where the datagram pulse is seen
  task automatic wait_dg;
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (dgram_valid !== 1'b1 && n < 12000);
    if (dgram_valid !== 1'b1) give_up();
  endtask : wait_dg

  // Reload from storage must finish before registers are touched
  task automatic wait_init;
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (flash_reload !== 1'b0 && n < 200);
    if (flash_reload !== 1'b0) give_up();
  endtask : wait_init

  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    comp_rate = 72'h000000FFF000001000;
    comp_temp = 48'h81000A80FF40;
    ext_trigger = 1'b0;
    utility_mode = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(72'(flash_reload), 72'h01);
    wait_init();
    rchk(`OFS_CTRL, `CTRL_RESET);
    apb(1'b0, 12'h034, 32'h0000_0000);
    chk({rd, 8'h00, 31'h0, err}, 72'h01);
    wr_trim_locked: begin
      apb(1'b1, `OFS_TRIM0, 32'h0000_0100);
      rchk(`OFS_TRIM0, 32'h0000_0000);
    end
    // Ratio 1, plain rate unit
    apb(1'b1, `OFS_CTRL, 32'h0000_0004);
    wait_dg();
    chk(rate_word_bytes, 72'h000000FFF000001000);
    chk(72'(temp_bytes), 72'(comp_temp));
    sc0 = sample_count;
    // Trim accepted in normal mode only with utility mode held
    utility_mode <= 1'b1;
    apb(1'b1, `OFS_TRIM0, 32'h0000_0100);
    utility_mode <= 1'b0;
    wait_dg();
    chk(72'(8'(sample_count - sc0)), 72'h01);
    chk(rate_word_bytes, 72'h000000FFF000001100);
    // Average over two samples that differ, trim added to each
    apb(1'b1, `OFS_CTRL, 32'h0000_0009);
    wait_dg();
    repeat (7500) @(posedge pclk);
    comp_rate <= 72'h000000FFF000003000;
    wait_dg();
    chk(rate_word_bytes, 72'h000000FFF000002100);
    // Integrated angle: 2000 units of rate give 128 units of angle per sample
    comp_rate <= 72'h000000FFF8300006D0;
    apb(1'b1, `OFS_CTRL, 32'h0000_0007);
    wait_dg();
    wait_dg();
    a0 = angle_word_bytes;
    sc0 = sample_count;
    wait_dg();
    a0 = {angle_word_bytes[71:48] - a0[71:48], angle_word_bytes[47:24] - a0[47:24],
      angle_word_bytes[23:0] - a0[23:0]};
    chk(a0, 72'h000000FFFF80000080);
    chk(72'(8'(sample_count - sc0)), 72'h01);
    // Trigger about 4000 cycles before the next slot
    repeat (1000) @(posedge pclk);
    ext_trigger <= 1'b1;
    repeat (10) @(posedge pclk);
    ext_trigger <= 1'b0;
    wait_dg();
    chk(72'(latency_bytes >= 16'h018E && latency_bytes <= 16'h0191), 72'h01);
    // Service mode: info first, then silence
    apb(1'b1, `OFS_CMD, 32'h0000_0001);
    chk({info_data, 39'h0, info_valid}, {`INFO_WORD, 40'h01});
    apb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk(72'(rd[1:0]), 72'(MODE_SERVICE));
    c0 = dgram_cnt;
    repeat (6000) @(posedge pclk);
    chk(72'(dgram_cnt - c0), 72'h00);
    apb(1'b1, `OFS_TRIM1, 32'h0000_0010);
    rchk(`OFS_TRIM1, 32'h0000_0010);
    apb(1'b1, `OFS_CMD, 32'h0000_0008);
    wait_dg();
    apb(1'b1, `OFS_CTRL, 32'h0000_0005);
    apb(1'b1, `OFS_CMD, 32'h0000_0006);
    apb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk(72'(rd[1:0]), 72'(MODE_NORMAL));
    rchk(`OFS_CTRL, 32'h0000_0005);
    wait_dg();
    // Exit to init restores the stored configuration
    apb(1'b1, `OFS_CMD, 32'h0000_0001);
    apb(1'b1, `OFS_CMD, 32'h0000_0002);
    @(posedge pclk);
    chk(72'(flash_reload), 72'h01);
    wait_init();
    rchk(`OFS_CTRL, `CTRL_RESET);
    // External reset while in service mode
    apb(1'b1, `OFS_CTRL, 32'h0000_0005);
    apb(1'b1, `OFS_CMD, 32'h0000_0001);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(72'(flash_reload), 72'h01);
    wait_init();
    rchk(`OFS_CTRL, `CTRL_RESET);
    report_and_stop();
  end
endmodule : gyro_output_unit_formatter_test
